// [rtc_evirq_defs.vh]
/*
  Constants for the event-output and interrupt-enable control of the real-time counter.
  Assumes it is included by bare name from the design files; definitions only.
*/
`ifndef RTC_EVIRQ_DEFS_VH
`define RTC_EVIRQ_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFF_EVENT_OUTPUT_CONTROL   8'h04
`define OFF_INTERRUPT_ENABLE_CLEAR 8'h06
`define OFF_INTERRUPT_ENABLE_SET   8'h07
`define OFF_INTERRUPT_FLAG         8'h08

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define RST_EVENT_OUTPUT_CONTROL   16'h0000
`define RST_INTERRUPT_ENABLE       8'h00
`define RST_INTERRUPT_FLAG         8'h00
`define MASK_EVENT_OUTPUT_CONTROL  16'h83FF
`define MASK_INTERRUPT             8'hC3

// ----------------------------------------------------------------
// Field positions in event_output_control
// ----------------------------------------------------------------
`define EV_PERIODIC_HI             7
`define EV_PERIODIC_LO             0
`define EV_COMPARE_ZERO_BIT        8
`define EV_ALARM_ZERO_BIT          8
`define EV_COMPARE_ONE_BIT         9
`define EV_OVERFLOW_BIT            15

// ----------------------------------------------------------------
// Field positions in the interrupt enable and flag registers
// ----------------------------------------------------------------
`define IRQ_OVERFLOW_BIT           7
`define IRQ_SYNC_READY_BIT         6
`define IRQ_COMPARE_ONE_BIT        1
`define IRQ_COMPARE_ZERO_BIT       0
`define IRQ_ALARM_ZERO_BIT         0

// ----------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------
`define MODE_COUNT32               2'h0
`define MODE_COUNT16               2'h1
`define MODE_CALENDAR              2'h2

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define ADDR_W                     8
`define DATA_W                     16
`define IRQ_W                      8

`endif

// [irq_flag_bank.v]
/*
  Bank of sticky interrupt flags, set by hardware events, cleared by writing ones.
  Assumes set and clear vectors are on CLK; a set in the clearing cycle wins.
*/
`include "rtc_evirq_defs.vh"

module irq_flag_bank #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire [W-1:0] set_vec,
  input  wire [W-1:0] clr_vec,
  output reg  [W-1:0] flag_reg
);

  // ----------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------
  reg [W-1:0] flag_next;

  // Set beats clear so an event in the clearing cycle is never lost
  always @* begin
    flag_next = (flag_reg & ~clr_vec) | set_vec;
  end

  // Async reset to a constant only
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= {W{1'b0}};
    end else begin
      flag_reg <= flag_next;
    end
  end

endmodule

// [rtc_event_irq_enable_ctrl.v]
/*
  Event-output enable and interrupt-enable control of a real-time counter with
  32-bit, 16-bit and clock/calendar modes, with sticky interrupt flags and one IRQ.
  Assumes the counter core, compare/alarm matching and sync-busy logic run on CLK
  and deliver one-cycle event pulses; register port is a plain strobe port.
*/
// Chosen here: the strobed register port.
`include "rtc_evirq_defs.vh"

module rtc_event_irq_enable_ctrl #(
  parameter TAPS = 8
) (
  input  wire                 CLK,
  input  wire                 RST_B,
  input  wire [`ADDR_W-1:0]   ADDR,
  input  wire [`DATA_W-1:0]   WDATA,
  input  wire                 WR,
  input  wire                 RD,
  output reg  [`DATA_W-1:0]   RDATA,
  input  wire [1:0]           COUNT_MODE,
  input  wire                 COUNTER_ENABLED,
  input  wire                 WRITE_LOCK,
  input  wire [TAPS-1:0]      PERIODIC_TICK,
  input  wire                 OVERFLOW,
  input  wire [1:0]           COMPARE_MATCH,
  input  wire                 ALARM_MATCH,
  input  wire                 SYNC_BUSY,
  input  wire                 SYNC_BY_ENABLE,
  output reg  [TAPS-1:0]      EV_PERIODIC,
  output reg                  EV_OVERFLOW,
  output reg  [1:0]           EV_COMPARE,
  output reg                  EV_ALARM_ZERO,
  output reg                  IRQ
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Address match used by every register decode
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Mode compare used by event and interrupt routing
  function in_mode;
    input [1:0] m;
    input [1:0] code;
    begin
      in_mode = (m == code);
    end
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire mode32;
  wire mode16;
  wire mode_cal;
  wire wr_event_output_control;
  wire wr_inten_clr;
  wire wr_inten_set;
  wire wr_flag;

  // Reserved mode code 3 routes no compare or alarm source
  assign mode32   = in_mode(COUNT_MODE, `MODE_COUNT32);
  assign mode16   = in_mode(COUNT_MODE, `MODE_COUNT16);
  assign mode_cal = in_mode(COUNT_MODE, `MODE_CALENDAR);

  // Event control is enable- and write-protected
  assign wr_event_output_control = WR & hit(ADDR, `OFF_EVENT_OUTPUT_CONTROL)
                   & ~COUNTER_ENABLED & ~WRITE_LOCK;
  // Enable registers are write-protected only
  assign wr_inten_clr = WR & hit(ADDR, `OFF_INTERRUPT_ENABLE_CLEAR) & ~WRITE_LOCK;
  assign wr_inten_set = WR & hit(ADDR, `OFF_INTERRUPT_ENABLE_SET) & ~WRITE_LOCK;
  // Flag clearing has no protection
  assign wr_flag = WR & hit(ADDR, `OFF_INTERRUPT_FLAG);

  // ----------------------------------------------------------------
  // Event output control register
  // ----------------------------------------------------------------
  reg [`DATA_W-1:0] event_output_control_reg;
  reg [`DATA_W-1:0] event_output_control_next;

  // Writes while running or locked are silently dropped
  always @* begin
    event_output_control_next = event_output_control_reg;
    if (wr_event_output_control) begin
      event_output_control_next = WDATA & `MASK_EVENT_OUTPUT_CONTROL;
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      event_output_control_reg <= `RST_EVENT_OUTPUT_CONTROL;
    end else begin
      event_output_control_reg <= event_output_control_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable, shared by clear and set views
  // ----------------------------------------------------------------
  reg  [`IRQ_W-1:0] inten_reg;
  reg  [`IRQ_W-1:0] inten_next;
  wire [`IRQ_W-1:0] wbyte;

  assign wbyte = WDATA[`IRQ_W-1:0] & `MASK_INTERRUPT;

  // Ones clear or set, zeros leave bits alone
  always @* begin
    inten_next = inten_reg;
    if (wr_inten_clr) begin
      // Bit 0 is compare-0 or alarm-0 by mode
      inten_next = inten_reg & ~wbyte;
    end else if (wr_inten_set) begin
      inten_next = inten_reg | wbyte;
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      inten_reg <= `RST_INTERRUPT_ENABLE;
    end else begin
      inten_reg <= inten_next;
    end
  end

  // ----------------------------------------------------------------
  // Sync-ready detection
  // ----------------------------------------------------------------
  reg sync_busy_reg;
  reg by_enable_reg;
  wire sync_ready_set;

  // Remember whether the busy period came from enable or software reset
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync_busy_reg <= 1'b0;
      by_enable_reg <= 1'b0;
    end else begin
      sync_busy_reg <= SYNC_BUSY;
      if (SYNC_BUSY & SYNC_BY_ENABLE) begin
        by_enable_reg <= 1'b1;
      end else if (~SYNC_BUSY) begin
        by_enable_reg <= 1'b0;
      end
    end
  end

  // Falling busy sets the flag unless enable/reset caused it
  assign sync_ready_set = sync_busy_reg & ~SYNC_BUSY
                        & ~by_enable_reg & ~SYNC_BY_ENABLE;

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  reg  [`IRQ_W-1:0] flag_set;
  wire [`IRQ_W-1:0] flag_clr;
  wire [`IRQ_W-1:0] flag_reg;

  // Route sources by mode; bit 0 is alarm in calendar mode
  always @* begin
    flag_set = {`IRQ_W{1'b0}};
    flag_set[`IRQ_OVERFLOW_BIT]   = OVERFLOW;
    flag_set[`IRQ_SYNC_READY_BIT] = sync_ready_set;
    flag_set[`IRQ_COMPARE_ZERO_BIT] = ((mode32 | mode16) & COMPARE_MATCH[0])
                                    | (mode_cal & ALARM_MATCH);
    flag_set[`IRQ_COMPARE_ONE_BIT]  = mode16 & COMPARE_MATCH[1];
  end

  assign flag_clr = wr_flag ? wbyte : {`IRQ_W{1'b0}};

  irq_flag_bank #(
    .W (`IRQ_W)
  ) u_flags (
    .clk      (CLK),
    .rst_b    (RST_B),
    .set_vec  (flag_set),
    .clr_vec  (flag_clr),
    .flag_reg (flag_reg)
  );

  // ----------------------------------------------------------------
  // Event outputs
  // ----------------------------------------------------------------

  // One-cycle pulses, registered so outputs come from flops
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      EV_PERIODIC   <= {TAPS{1'b0}};
      EV_OVERFLOW   <= 1'b0;
      EV_COMPARE    <= 2'h0;
      EV_ALARM_ZERO <= 1'b0;
    end else begin
      EV_PERIODIC   <= PERIODIC_TICK
                     & event_output_control_reg[`EV_PERIODIC_HI:`EV_PERIODIC_LO];
      EV_OVERFLOW   <= OVERFLOW & event_output_control_reg[`EV_OVERFLOW_BIT];
      EV_COMPARE[0] <= (mode32 | mode16) & COMPARE_MATCH[0]
                     & event_output_control_reg[`EV_COMPARE_ZERO_BIT];
      EV_COMPARE[1] <= mode16 & COMPARE_MATCH[1] & event_output_control_reg[`EV_COMPARE_ONE_BIT];
      EV_ALARM_ZERO <= mode_cal & ALARM_MATCH & event_output_control_reg[`EV_ALARM_ZERO_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------

  // Level output, one cycle behind flag or enable change
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(flag_reg & inten_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  reg [`DATA_W-1:0] rdata_next;

  // Both enable views read one shared state; unmapped reads zero
  always @* begin
    rdata_next = {`DATA_W{1'b0}};
    if (RD) begin
      if (hit(ADDR, `OFF_EVENT_OUTPUT_CONTROL)) begin
        rdata_next = event_output_control_reg;
      end else if (hit(ADDR, `OFF_INTERRUPT_ENABLE_CLEAR)
                   | hit(ADDR, `OFF_INTERRUPT_ENABLE_SET)) begin
        rdata_next = {{(`DATA_W-`IRQ_W){1'b0}}, inten_reg};
      end else if (hit(ADDR, `OFF_INTERRUPT_FLAG)) begin
        rdata_next = {{(`DATA_W-`IRQ_W){1'b0}}, flag_reg};
      end
    end
  end

  // Held only the cycle after the strobe; zero otherwise
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= {`DATA_W{1'b0}};
    end else begin
      RDATA <= rdata_next;
    end
  end

endmodule

// [rtc_evirq_checker.sv]
/*
  Port-level assertions for the event and interrupt-enable control block.
  Assumes one clock CLK and the asynchronous active-low reset RST_B.
*/
module rtc_evirq_checker #(
  parameter TAPS = 8
) (
  input wire logic            CLK,
  input wire logic            RST_B,
  input wire logic [7:0]      ADDR,
  input wire logic [15:0]     WDATA,
  input wire logic            WR,
  input wire logic            RD,
  input wire logic [15:0]     RDATA,
  input wire logic [1:0]      COUNT_MODE,
  input wire logic            WRITE_LOCK,
  input wire logic [TAPS-1:0] PERIODIC_TICK,
  input wire logic            OVERFLOW,
  input wire logic [1:0]      COMPARE_MATCH,
  input wire logic            ALARM_MATCH,
  input wire logic            SYNC_BUSY,
  input wire logic [TAPS-1:0] EV_PERIODIC,
  input wire logic            EV_OVERFLOW,
  input wire logic            EV_ALARM_ZERO,
  input wire logic            IRQ
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside read slot");
  chk_clear_narrow: assert property (RD && ADDR == 8'h06 |=> RDATA[15:8] == 8'h00)
    else $error("upper enable bits not zero");
  chk_tick_gate: assert property ((EV_PERIODIC & ~$past(PERIODIC_TICK)) == '0)
    else $error("periodic event without tick");
  chk_ovf_event: assert property (EV_OVERFLOW |-> $past(OVERFLOW))
    else $error("overflow event without cause");
  chk_alarm_mode: assert property (EV_ALARM_ZERO |-> $past(ALARM_MATCH) && $past(COUNT_MODE) == 2'h2)
    else $error("alarm event outside calendar mode");
  chk_clear_read: assert property (WR && ADDR == 8'h06 && WDATA[7] && !WRITE_LOCK ##1 !WR
    ##1 RD && ADDR == 8'h06 |=> !RDATA[7])
    else $error("overflow enable not cleared");
  chk_set_shared: assert property (WR && ADDR == 8'h07 && WDATA[7] && !WRITE_LOCK ##1 !WR
    ##1 RD && ADDR == 8'h06 |=> RDATA[7])
    else $error("set not seen in clear view");
  chk_irq_fall: assert property ($fell(IRQ) |-> $past(WR, 2) || $past(WR))
    else $error("request dropped without write");
  chk_irq_rise: assert property ($rose(IRQ) |-> $past(WR, 2) || $past(OVERFLOW, 2) || $past(WR)
    || (!$past(SYNC_BUSY, 2) && $past(SYNC_BUSY, 3)) || $past(|COMPARE_MATCH, 2)
    || $past(ALARM_MATCH, 2))
    else $error("request raised without cause");

  // Main scenarios reached
  cover property (EV_OVERFLOW);
  cover property (EV_ALARM_ZERO);
  cover property ($rose(IRQ));
endmodule

bind rtc_event_irq_enable_ctrl rtc_evirq_checker #(.TAPS(TAPS)) u_chk (
  .CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .COUNT_MODE(COUNT_MODE), .WRITE_LOCK(WRITE_LOCK), .PERIODIC_TICK(PERIODIC_TICK),
  .OVERFLOW(OVERFLOW), .COMPARE_MATCH(COMPARE_MATCH), .ALARM_MATCH(ALARM_MATCH),
  .SYNC_BUSY(SYNC_BUSY),
  .EV_PERIODIC(EV_PERIODIC), .EV_OVERFLOW(EV_OVERFLOW), .EV_ALARM_ZERO(EV_ALARM_ZERO), .IRQ(IRQ));

// [tb_rtc_event_irq_enable_ctrl.sv]
/*
  Self-checking bench for the event and interrupt-enable control block.
  Assumes the register port answers reads one cycle later and never stalls.
*/
module tb_rtc_event_irq_enable_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 0, RST_B = 0, WR = 0, RD = 0, OVERFLOW = 0, ALARM_MATCH = 0;
  logic        SYNC_BUSY = 0, SYNC_BY_ENABLE = 0, COUNTER_ENABLED = 0, WRITE_LOCK = 0;
  logic [7:0]  ADDR = 8'h00, PERIODIC_TICK = 8'h00;
  logic [15:0] WDATA = 16'h0000;
  logic [1:0]  COUNT_MODE = 2'h2, COMPARE_MATCH = 2'h0;
  wire  [15:0] RDATA;
  wire  [7:0]  EV_PERIODIC;
  wire  [1:0]  EV_COMPARE;
  wire         EV_OVERFLOW, EV_ALARM_ZERO, IRQ;
  int          err_total = 0, checks = 0;

  rtc_event_irq_enable_ctrl #(.TAPS(8)) dut (
    .CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .COUNT_MODE(COUNT_MODE), .COUNTER_ENABLED(COUNTER_ENABLED), .WRITE_LOCK(WRITE_LOCK),
    .PERIODIC_TICK(PERIODIC_TICK), .OVERFLOW(OVERFLOW), .COMPARE_MATCH(COMPARE_MATCH),
    .ALARM_MATCH(ALARM_MATCH), .SYNC_BUSY(SYNC_BUSY), .SYNC_BY_ENABLE(SYNC_BY_ENABLE),
    .EV_PERIODIC(EV_PERIODIC), .EV_OVERFLOW(EV_OVERFLOW), .EV_COMPARE(EV_COMPARE),
    .EV_ALARM_ZERO(EV_ALARM_ZERO), .IRQ(IRQ));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 CLK = ~CLK;
  end

  task chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %0t saw %h want %h", $time, s, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA, e);
  endtask

  task pulse(input logic [7:0] t, input logic o, input logic [1:0] c, input logic al);
    @(posedge CLK);
    PERIODIC_TICK <= t;
    OVERFLOW <= o;
    COMPARE_MATCH <= c;
    ALARM_MATCH <= al;
    @(posedge CLK);
    PERIODIC_TICK <= 8'h00;
    OVERFLOW <= 1'b0;
    COMPARE_MATCH <= 2'h0;
    ALARM_MATCH <= 1'b0;
    #1;
  endtask

  task wait_n(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task close_out;
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rd(8'h04, 16'h0000);
    rd(8'h06, 16'h0000);
    rd(8'h10, 16'h0000);
  endtask

  // Protection must hold while enabled and while locked
  task t_protect;
    wr(8'h04, 16'hFFFF);
    rd(8'h04, 16'h83FF);
    COUNTER_ENABLED <= 1'b1;
    wr(8'h04, 16'h0000);
    rd(8'h04, 16'h83FF);
    COUNTER_ENABLED <= 1'b0;
    WRITE_LOCK <= 1'b1;
    wr(8'h04, 16'h0000);
    wr(8'h07, 16'h00FF);
    rd(8'h04, 16'h83FF);
    rd(8'h06, 16'h0000);
    WRITE_LOCK <= 1'b0;
  endtask

  task t_events;
    wr(8'h04, 16'h8155);
    pulse(8'hFF, 1'b1, 2'h0, 1'b1);
    chk({6'h00, EV_OVERFLOW, EV_ALARM_ZERO, EV_PERIODIC}, 16'h0355);
    COUNT_MODE <= 2'h0;
    pulse(8'hAA, 1'b1, 2'h3, 1'b1);
    chk({6'h00, EV_OVERFLOW, EV_ALARM_ZERO, EV_PERIODIC}, 16'h0200);
    chk(EV_COMPARE, 16'h0001);
    wr(8'h04, 16'h0000);
    pulse(8'hFF, 1'b1, 2'h0, 1'b0);
    chk({6'h00, EV_OVERFLOW, EV_ALARM_ZERO, EV_PERIODIC}, 16'h0000);
  endtask

  task t_ovf_irq;
    wr(8'h07, 16'h0080);
    rd(8'h06, 16'h0080);
    pulse(8'h00, 1'b1, 2'h0, 1'b0);
    wait_n(1);
    chk(IRQ, 1'b1);
    wr(8'h06, 16'h0000);
    rd(8'h06, 16'h0080);
    chk(IRQ, 1'b1);
    wr(8'h06, 16'h0080);
    rd(8'h06, 16'h0000);
    chk(IRQ, 1'b0);
    wr(8'h08, 16'h0080);
  endtask

  // A busy period started by enable must not raise the ready flag
  task t_sync;
    wr(8'h07, 16'h0040);
    SYNC_BUSY <= 1'b1;
    wait_n(3);
    SYNC_BUSY <= 1'b0;
    wait_n(3);
    chk(IRQ, 1'b1);
    wr(8'h08, 16'h0040);
    SYNC_BY_ENABLE <= 1'b1;
    SYNC_BUSY <= 1'b1;
    wait_n(3);
    SYNC_BUSY <= 1'b0;
    wait_n(1);
    SYNC_BY_ENABLE <= 1'b0;
    wait_n(3);
    chk(IRQ, 1'b0);
    wr(8'h06, 16'h0040);
    rd(8'h06, 16'h0000);
  endtask

  task t_modes;
    for (int m = 0; m < 3; m++) begin
      COUNT_MODE <= m[1:0];
      wr(8'h07, 16'h0003);
      pulse(8'h00, 1'b0, (m == 2) ? 2'h0 : ((m == 1) ? 2'h2 : 2'h1), m == 2);
      wait_n(1);
      chk(IRQ, 1'b1);
      wr(8'h06, (m == 1) ? 16'h0002 : 16'h0001);
      wait_n(2);
      chk(IRQ, 1'b0);
      rd(8'h06, (m == 1) ? 16'h0001 : 16'h0002);
      wr(8'h08, 16'h0003);
      wr(8'h06, 16'h0003);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge CLK);
    RST_B <= 1'b1;
    t_reset;
    t_protect;
    t_events;
    t_ovf_irq;
    t_sync;
    t_modes;
    close_out;
  end

  initial begin
    #200000;
    err_total++;
    close_out;
  end
endmodule
